//--- mre_pkg.sv
`default_nettype none
package mre_pkg;
	// bus register byte addresses
	localparam logic [3:0]  ADR_MODE         = 4'h0;
	localparam logic [3:0]  ADR_CTRL         = 4'h4;
	localparam logic [3:0]  ADR_STAT         = 4'h8;
	// operating mode indication layout
	localparam int          MODE_LOWER_BIT   = 0;
	localparam int          MODE_UPPER_BIT   = 1;
	localparam int          EXP_PERMIT_BIT   = 7;
	localparam logic [7:0]  MODE_FIXED_ONES  = 8'h64;
	localparam logic [7:0]  MODE_FIXED_MASK  = 8'h7C;
	localparam logic        EXP_PERMIT_RESET = 1'h1;
	// control register layout
	localparam int          CTRL_RAM_EN_BIT  = 0;
	localparam int          CTRL_WDT_RST_BIT = 1;
	localparam logic [1:0]  CTRL_RESET       = 2'h1;
	// status register layout
	localparam int          STAT_EXT_BIT     = 0;
	localparam int          STAT_BLOCK_BIT   = 1;
	localparam int          STAT_HOLD_BIT    = 2;
	// strap encodings
	localparam logic [1:0]  MODE_NONE        = 2'h0;
	localparam logic [1:0]  MODE_EXP_NOROM   = 2'h1;
	localparam logic [1:0]  MODE_EXP_ROM     = 2'h2;
	localparam logic [1:0]  MODE_SINGLE      = 2'h3;
	// address map
	localparam logic [15:0] ROM_FIRST        = 16'h0000;
	localparam logic [15:0] ROM_LAST         = 16'h7FFF;
	localparam logic [15:0] RAM_FIRST        = 16'hFB80;
	localparam logic [15:0] RAM_LAST         = 16'hFF7F;
	localparam int          RAM_BYTES        = 1024;
	localparam logic [15:0] EXTWIN_FIRST     = 16'hFF80;
	localparam logic [15:0] EXTWIN_LAST      = 16'hFF87;
	localparam logic [15:0] REGS_FIRST       = 16'hFF88;
	localparam logic [15:0] RESET_VECTOR     = 16'h0000;
	// timing
	localparam logic [9:0]  WDT_PULSE_CYCLES = 10'h206;
	typedef enum logic [1:0] {SEQ_HOLD, SEQ_MASK, SEQ_VEC, SEQ_RUN} mre_seq_e;
endpackage : mre_pkg
`default_nettype wire

//--- mre_wdt_pulse.sv
`default_nettype none
module mre_wdt_pulse (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic trigger,
	output logic      active_r
);
	logic [9:0] cnt_r;
	logic [9:0] len_r;
	wire        start = trigger && !active_r;
	wire        last  = active_r && (cnt_r == 10'h000);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			active_r <= 1'b0;
			cnt_r    <= 10'h000;
		end else if (start) begin
			active_r <= 1'b1;
			cnt_r    <= mre_pkg::WDT_PULSE_CYCLES - 10'h001;
		end else if (last) begin
			active_r <= 1'b0;
		end else if (active_r) begin
			cnt_r    <= cnt_r - 10'h001;
		end
	end

	// helper: length of the current pulse
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			len_r <= 10'h000;
		end else if (active_r) begin
			len_r <= len_r + 10'h001;
		end else begin
			len_r <= 10'h000;
		end
	end

	wdt_width_a: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(active_r) |-> $past(len_r) == mre_pkg::WDT_PULSE_CYCLES - 10'h001)
		else $error("watchdog reset pulse length wrong");
	wdt_cover_c: cover property (@(posedge clk) disable iff (!rst_n) $fell(active_r));
endmodule : mre_wdt_pulse
`default_nettype wire

//--- mre_addr_map.sv
`default_nettype none
module mre_addr_map (
	input  wire logic [15:0] addr,
	input  wire logic [1:0]  mode,
	input  wire logic        ram_en,
	output logic             sel_rom,
	output logic             sel_ram,
	output logic             sel_regs,
	output logic             sel_ext
);
	wire expanded = (mode == mre_pkg::MODE_EXP_NOROM) || (mode == mre_pkg::MODE_EXP_ROM);
	wire rom_on   = (mode == mre_pkg::MODE_EXP_ROM) || (mode == mre_pkg::MODE_SINGLE);
	wire in_rom   = (addr >= mre_pkg::ROM_FIRST) && (addr <= mre_pkg::ROM_LAST);
	wire in_ram   = (addr >= mre_pkg::RAM_FIRST) && (addr <= mre_pkg::RAM_LAST);
	wire in_regs  = (addr >= mre_pkg::REGS_FIRST);
	wire live     = (mode != mre_pkg::MODE_NONE);

	assign sel_rom  = live && rom_on && in_rom;
	assign sel_ram  = live && in_ram && (ram_en || (mode == mre_pkg::MODE_SINGLE));
	assign sel_regs = live && in_regs;
	assign sel_ext  = expanded && !sel_rom && !sel_ram && !sel_regs;
endmodule : mre_addr_map
`default_nettype wire

//--- mre_top.sv
// Contract
// - mode bits 1:0 read-only, mirror the two strap pins, upper to upper
// - every read of the mode register samples the strap pins afresh
// - without the expanded-permit function bit 7 always reads 1
// - reserved mode bits ignore writes; bits 6,5,2 read 1, bits 4,3 read 0
// - 1024-byte RAM sits at FB80 to FF7F in all three modes
// - reset outranks every interrupt and is detected on the system clock
// - interrupts start only at instruction end or exception sequence end
// - no interrupt detection at the boundary after a flag instruction
// - reset pin low or watchdog reset stops processing and initialises state
// - reset sequence starts on reset pin rising or watchdog pulse end
// - watchdog reset lasts exactly 518 system clocks
// - first sequence step sets the interrupt mask flag
// - program counter loads from the vector word at 0000/0001
// - all interrupts, NMI included, blocked right after reset
// - after a flag instruction interrupts wait until the next one runs
// - strap 00 inoperative, 01 expanded no ROM, 10 expanded ROM, 11 single
`default_nettype none
module mre_top #(
	parameter bit EXP_PERMIT_PRESENT = 1'b0
) (
	input  wire logic        CLK_SYS,
	input  wire logic        RST_N,
	input  wire logic [3:0]  WB_ADR_I,
	input  wire logic [31:0] WB_DAT_I,
	input  wire logic [3:0]  WB_SEL_I,
	input  wire logic        WB_WE_I,
	input  wire logic        WB_CYC_I,
	input  wire logic        WB_STB_I,
	output logic             WB_ACK_O,
	output logic [31:0]      WB_DAT_O,
	input  wire logic        RES_PIN_N,
	input  wire logic        STRAP_PIN_UPPER,
	input  wire logic        STRAP_PIN_LOWER,
	input  wire logic        WDT_OVERFLOW,
	input  wire logic        INSTR_END,
	input  wire logic        INSTR_FLAG_OP,
	input  wire logic        EXC_SEQ_END,
	input  wire logic        IRQ_PENDING,
	input  wire logic        NMI_PENDING,
	input  wire logic        CPU_IMASK,
	input  wire logic [15:0] VEC_DATA,
	input  wire logic        VEC_VALID,
	input  wire logic [15:0] CPU_ADDR,
	output logic             CORE_HOLD,
	output logic             FLAG_MASK_SET,
	output logic             VEC_REQ,
	output logic [15:0]      VEC_ADDR,
	output logic             PC_LOAD,
	output logic [15:0]      PC_VALUE,
	output logic             INT_TAKE,
	output logic             INT_IS_NMI,
	output logic             MODE_FAULT,
	output logic             DEC_ROM,
	output logic             DEC_RAM,
	output logic             DEC_REGS,
	output logic             DEC_EXT
);
	// pin synchronisers: reset pin and straps
	logic [2:0]       pin_meta_r;
	logic [2:0]       pin_sync_r;
	logic [1:0]       mode_bits_r;
	logic [1:0]       mode_run_r;
	logic             exp_permit_r;
	logic [1:0]       ctrl_r;
	logic             ext_cause_r;
	logic             block_r;
	logic             wdt_active;
	logic             sel_rom;
	logic             sel_ram;
	logic             sel_regs;
	logic             sel_ext;
	mre_pkg::mre_seq_e state_r;
	mre_pkg::mre_seq_e state_nxt;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			pin_meta_r <= 3'h0;
			pin_sync_r <= 3'h0;
		end else begin
			pin_meta_r <= {RES_PIN_N, STRAP_PIN_UPPER, STRAP_PIN_LOWER};
			pin_sync_r <= pin_meta_r;
		end
	end

	wire       res_pin_s = pin_sync_r[2];
	wire [1:0] strap_s   = pin_sync_r[1:0];
	wire       in_reset  = !res_pin_s || wdt_active;

	mre_wdt_pulse u_wdt (
		.clk      (CLK_SYS),
		.rst_n    (RST_N),
		.trigger  (WDT_OVERFLOW && ctrl_r[mre_pkg::CTRL_WDT_RST_BIT]),
		.active_r (wdt_active)
	);

	// bus decode
	wire        bus_req  = WB_CYC_I && WB_STB_I && !WB_ACK_O;
	wire        hit_mode = (WB_ADR_I == mre_pkg::ADR_MODE);
	wire        hit_ctrl = (WB_ADR_I == mre_pkg::ADR_CTRL);
	wire        hit_stat = (WB_ADR_I == mre_pkg::ADR_STAT);
	wire        rd_mode  = bus_req && !WB_WE_I && hit_mode;
	wire        wr_ctrl  = bus_req && WB_WE_I && hit_ctrl && WB_SEL_I[0];
	wire        wr_mode  = bus_req && WB_WE_I && hit_mode && WB_SEL_I[0];
	wire        bit7_val = EXP_PERMIT_PRESENT ? exp_permit_r : 1'b1;
	wire [7:0]  mode_rd  = mre_pkg::MODE_FIXED_ONES
	                     | {bit7_val, 5'h00, strap_s};
	wire [7:0]  ctrl_rd  = {6'h00, ctrl_r};
	wire [7:0]  stat_rd  = {5'h00, CORE_HOLD, block_r, ext_cause_r};
	wire [7:0]  rd_byte  = hit_mode ? mode_rd :
	                       hit_ctrl ? ctrl_rd :
	                       hit_stat ? stat_rd : 8'h00;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
		end else begin
			WB_ACK_O <= bus_req;
			WB_DAT_O <= (bus_req && !WB_WE_I) ? {24'h000000, rd_byte} : 32'h00000000;
		end
	end

	// mode bits change only by strap capture, never by writes
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			mode_bits_r <= 2'h0;
		end else if (rd_mode || (state_r == mre_pkg::SEQ_HOLD && !in_reset)) begin
			mode_bits_r <= strap_s;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			mode_run_r <= 2'h0;
		end else if (state_r == mre_pkg::SEQ_HOLD && !in_reset) begin
			mode_run_r <= strap_s;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			exp_permit_r <= mre_pkg::EXP_PERMIT_RESET;
			ctrl_r       <= mre_pkg::CTRL_RESET;
		end else if (in_reset) begin
			exp_permit_r <= mre_pkg::EXP_PERMIT_RESET;
			ctrl_r       <= mre_pkg::CTRL_RESET;
		end else begin
			if (wr_mode && EXP_PERMIT_PRESENT) begin
				exp_permit_r <= WB_DAT_I[mre_pkg::EXP_PERMIT_BIT];
			end
			if (wr_ctrl) begin
				ctrl_r <= WB_DAT_I[1:0];
			end
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ext_cause_r <= 1'b1;
		end else if (!res_pin_s) begin
			ext_cause_r <= 1'b1;
		end else if (wdt_active) begin
			ext_cause_r <= 1'b0;
		end
	end

	// reset exception sequence
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			mre_pkg::SEQ_HOLD: begin
				if (!in_reset) state_nxt = mre_pkg::SEQ_MASK;
			end
			mre_pkg::SEQ_MASK: state_nxt = mre_pkg::SEQ_VEC;
			mre_pkg::SEQ_VEC: begin
				if (VEC_VALID) state_nxt = mre_pkg::SEQ_RUN;
			end
			mre_pkg::SEQ_RUN: state_nxt = mre_pkg::SEQ_RUN;
			default: state_nxt = mre_pkg::SEQ_HOLD;
		endcase
		if (in_reset) state_nxt = mre_pkg::SEQ_HOLD;
	end

	wire go_mask  = (state_r == mre_pkg::SEQ_HOLD) && !in_reset;
	wire vec_done = (state_r == mre_pkg::SEQ_VEC) && VEC_VALID && !in_reset;

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			state_r       <= mre_pkg::SEQ_HOLD;
			CORE_HOLD     <= 1'b1;
			FLAG_MASK_SET <= 1'b0;
			VEC_REQ       <= 1'b0;
			VEC_ADDR      <= mre_pkg::RESET_VECTOR;
			PC_LOAD       <= 1'b0;
			PC_VALUE      <= 16'h0000;
		end else begin
			state_r       <= state_nxt;
			CORE_HOLD     <= (state_nxt != mre_pkg::SEQ_RUN);
			FLAG_MASK_SET <= go_mask;
			VEC_REQ       <= (state_nxt == mre_pkg::SEQ_VEC);
			VEC_ADDR      <= mre_pkg::RESET_VECTOR;
			PC_LOAD       <= vec_done;
			if (vec_done) PC_VALUE <= VEC_DATA;
		end
	end

	// interrupt acceptance
	wire boundary  = INSTR_END || EXC_SEQ_END;
	wire flag_gap  = INSTR_END && INSTR_FLAG_OP;
	wire may_take  = (state_r == mre_pkg::SEQ_RUN) && !in_reset && !block_r && !flag_gap;
	wire want_irq  = IRQ_PENDING && !CPU_IMASK;
	wire take      = boundary && may_take && (NMI_PENDING || want_irq);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			block_r    <= 1'b1;
			INT_TAKE   <= 1'b0;
			INT_IS_NMI <= 1'b0;
		end else begin
			if (state_r != mre_pkg::SEQ_RUN || in_reset) begin
				block_r <= 1'b1;
			end else if (INSTR_END) begin
				block_r <= INSTR_FLAG_OP;
			end
			INT_TAKE   <= take;
			INT_IS_NMI <= take && NMI_PENDING;
		end
	end

	// address map
	mre_addr_map u_map (
		.addr     (CPU_ADDR),
		.mode     (mode_run_r),
		.ram_en   (ctrl_r[mre_pkg::CTRL_RAM_EN_BIT]),
		.sel_rom  (sel_rom),
		.sel_ram  (sel_ram),
		.sel_regs (sel_regs),
		.sel_ext  (sel_ext)
	);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			DEC_ROM    <= 1'b0;
			DEC_RAM    <= 1'b0;
			DEC_REGS   <= 1'b0;
			DEC_EXT    <= 1'b0;
			MODE_FAULT <= 1'b0;
		end else begin
			DEC_ROM    <= sel_rom;
			DEC_RAM    <= sel_ram;
			DEC_REGS   <= sel_regs;
			DEC_EXT    <= sel_ext;
			MODE_FAULT <= (mode_run_r == mre_pkg::MODE_NONE) && !CORE_HOLD;
		end
	end

	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	mode_ro_a: assert property (wr_mode |=> mode_bits_r == $past(mode_bits_r))
		else $error("mode bits changed by a write");
	mode_sample_a: assert property (rd_mode |=> WB_ACK_O && WB_DAT_O[1:0] == $past(strap_s)
		&& mode_bits_r == $past(strap_s))
		else $error("mode read did not sample straps");
	bit7_one_a: assert property (rd_mode && !EXP_PERMIT_PRESENT |=> WB_DAT_O[7])
		else $error("bit 7 not read as one");
	fixed_bits_a: assert property (rd_mode |=> WB_DAT_O[6:2] == 5'h19)
		else $error("reserved mode bits wrong");
	ram_window_a: assert property (CPU_ADDR >= mre_pkg::RAM_FIRST && CPU_ADDR <= mre_pkg::RAM_LAST
		&& mode_run_r == mre_pkg::MODE_SINGLE |=> DEC_RAM && !DEC_EXT)
		else $error("RAM window not decoded");
	reset_first_a: assert property (in_reset |=> !INT_TAKE ##1 !INT_TAKE)
		else $error("interrupt taken during reset");
	take_boundary_a: assert property (INT_TAKE |-> $past(boundary))
		else $error("interrupt taken off a boundary");
	flag_gap_a: assert property (flag_gap |=> !INT_TAKE)
		else $error("interrupt after flag instruction");
	hold_core_a: assert property (in_reset |=> CORE_HOLD && !PC_LOAD)
		else $error("core not held in reset");
	seq_start_a: assert property ($fell(in_reset) |=> FLAG_MASK_SET ##1 VEC_REQ)
		else $error("reset sequence did not start");
	vec_load_a: assert property (vec_done |=> PC_LOAD && PC_VALUE == $past(VEC_DATA)
		&& VEC_ADDR == mre_pkg::RESET_VECTOR)
		else $error("vector load wrong");
	post_block_a: assert property (PC_LOAD |-> block_r)
		else $error("interrupts open after reset");
	release_a: assert property (state_r == mre_pkg::SEQ_RUN && !in_reset && INSTR_END
		&& !INSTR_FLAG_OP |=> !block_r)
		else $error("block not released");
	ext_single_a: assert property (DEC_EXT |-> $past(mode_run_r) != mre_pkg::MODE_SINGLE)
		else $error("external access in single-chip");

	cov_vec_c: cover property (vec_done ##1 PC_LOAD);
	cov_nmi_c: cover property (INT_TAKE && INT_IS_NMI);
	cov_mode_c: cover property (rd_mode);
	cov_gap_c: cover property (flag_gap && NMI_PENDING);
endmodule : mre_top
`default_nettype wire

//--- mre_src.sv
`default_nettype none
module mre_src #(
	parameter int PWR_CYCLES = 30
) (
	input  wire logic       clk,
	input  wire logic       reset_req,
	input  wire logic [1:0] strap_set,
	output logic            res_pin_n,
	output logic            strap_upper,
	output logic            strap_lower
);
	timeunit 1ns;
	timeprecision 1ps;
	int low_cnt;
	// power-up hold, scaled down to keep the run short
	initial low_cnt = PWR_CYCLES;
	always @(posedge clk) begin
		if (reset_req)
			low_cnt <= 12;
		else if (low_cnt > 0)
			low_cnt <= low_cnt - 1;
	end
	assign res_pin_n   = (low_cnt == 0);
	assign strap_upper = strap_set[1];
	assign strap_lower = strap_set[0];
endmodule : mre_src
`default_nettype wire

//--- testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0, rst_n = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, rreq = 1'b0;
	logic [3:0] adr = 4'h0, sel = 4'h0;
	logic [31:0] dat = 32'h0, rdat;
	logic [1:0] strap = 2'h3;
	logic wdt = 1'b0, iend = 1'b0, iflag = 1'b0, xend = 1'b0, irq = 1'b0, nmi = 1'b0;
	logic imask = 1'b0, vvalid = 1'b0, mask_seen = 1'b0;
	logic [15:0] vdata = 16'h0, caddr = 16'h0, vaddr, pcv;
	logic ack, res_n, s_up, s_lo, hold, fmask, vreq, pcl, itake, inmi, mfault;
	logic d_rom, d_ram, d_regs, d_ext;
	int err_total = 0, comparisons = 0;
	always #2 clk = ~clk;
	always @(posedge clk) if (fmask === 1'b1) mask_seen <= 1'b1;
	mre_src mre_src_i (.clk(clk), .reset_req(rreq), .strap_set(strap), .res_pin_n(res_n),
		.strap_upper(s_up), .strap_lower(s_lo));
	mre_top mre_top_i (.CLK_SYS(clk), .RST_N(rst_n), .WB_ADR_I(adr), .WB_DAT_I(dat),
		.WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_ACK_O(ack),
		.WB_DAT_O(rdat), .RES_PIN_N(res_n), .STRAP_PIN_UPPER(s_up), .STRAP_PIN_LOWER(s_lo),
		.WDT_OVERFLOW(wdt), .INSTR_END(iend), .INSTR_FLAG_OP(iflag), .EXC_SEQ_END(xend),
		.IRQ_PENDING(irq), .NMI_PENDING(nmi), .CPU_IMASK(imask), .VEC_DATA(vdata),
		.VEC_VALID(vvalid), .CPU_ADDR(caddr), .CORE_HOLD(hold), .FLAG_MASK_SET(fmask),
		.VEC_REQ(vreq), .VEC_ADDR(vaddr), .PC_LOAD(pcl), .PC_VALUE(pcv), .INT_TAKE(itake),
		.INT_IS_NMI(inmi), .MODE_FAULT(mfault), .DEC_ROM(d_rom), .DEC_RAM(d_ram),
		.DEC_REGS(d_regs), .DEC_EXT(d_ext));
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic print_verdict();
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : print_verdict
	task automatic wb(input logic [3:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		adr <= a;
		we  <= w;
		dat <= d;
		sel <= 4'h1;
		cyc <= 1'b1;
		stb <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1);
		q = rdat;
		check("bus_ack_cycles", n, 32'h2);
		cyc <= 1'b0;
		stb <= 1'b0;
		we  <= 1'b0;
	endtask : wb
	task automatic boot(input logic [15:0] vec);
		int n;
		n = 0;
		while (vreq !== 1'b1 && n < 2000) begin @(posedge clk); #1; n++; end
		check("mask_before_vec", mask_seen, 1'b1);
		check("vec_addr", vaddr, mre_pkg::RESET_VECTOR);
		@(posedge clk); vdata <= vec; vvalid <= 1'b1;
		@(posedge clk); vvalid <= 1'b0;
		#1 check("pc_load", pcl, 1'b1);
		check("pc_value", pcv, vec);
		check("hold_off", hold, 1'b0);
	endtask : boot
	task automatic ext_reset(input logic [1:0] m);
		@(posedge clk); strap <= m; mask_seen <= 1'b0; rreq <= 1'b1;
		@(posedge clk); rreq <= 1'b0;
		repeat (6) @(posedge clk);
		#1 check("hold_in_reset", hold, 1'b1);
		check("no_seq_while_low", mask_seen, 1'b0);
		boot(16'hA5C3);
	endtask : ext_reset
	task automatic bnd(input logic f, input logic x, input logic tk, input logic nm);
		@(posedge clk); iend <= ~x; iflag <= f; xend <= x;
		@(posedge clk); iend <= 1'b0; iflag <= 1'b0; xend <= 1'b0;
		#1 check("int_take", itake, tk);
		if (tk) check("int_nmi", inmi, nm);
	endtask : bnd
	task automatic t_ints();
		@(posedge clk); nmi <= 1'b1;
		repeat (3) @(posedge clk);
		#1 check("no_bnd_no_take", itake, 1'b0);
		bnd(1'b1, 1'b0, 1'b0, 1'b0);
		@(posedge clk); nmi <= 1'b0;
		bnd(1'b0, 1'b0, 1'b0, 1'b0);
		@(posedge clk); nmi <= 1'b1;
		bnd(1'b0, 1'b0, 1'b1, 1'b1);
		bnd(1'b1, 1'b0, 1'b0, 1'b0);
		@(posedge clk); nmi <= 1'b0;
		bnd(1'b0, 1'b0, 1'b0, 1'b0);
		@(posedge clk); irq <= 1'b1; imask <= 1'b1;
		bnd(1'b0, 1'b0, 1'b0, 1'b0);
		@(posedge clk); imask <= 1'b0;
		bnd(1'b0, 1'b1, 1'b1, 1'b0);
		@(posedge clk); irq <= 1'b0;
	endtask : t_ints
	task automatic t_wdt();
		logic [31:0] q;
		int n;
		wb(mre_pkg::ADR_CTRL, 1'b1, 32'h3, q);
		@(posedge clk); wdt <= 1'b1; mask_seen <= 1'b0;
		@(posedge clk); wdt <= 1'b0;
		n = 1;
		while (fmask !== 1'b1 && n < 700) begin @(posedge clk); #1; n++; end
		check("wdt_len", (n >= 518 && n <= 522), 1'b1);
		boot(16'h0F1E);
		wb(mre_pkg::ADR_STAT, 1'b0, 32'h0, q);
		check("stat_wdt", q[mre_pkg::STAT_EXT_BIT], 1'b0);
		wb(mre_pkg::ADR_CTRL, 1'b0, 32'h0, q);
		check("ctrl_init", q, {30'h0, mre_pkg::CTRL_RESET});
		@(posedge clk);
		wdt <= 1'b1;
		@(posedge clk);
		wdt <= 1'b0;
		repeat (4) @(posedge clk);
		#1 check("wdt_gated", hold, 1'b0);
	endtask : t_wdt
	task automatic t_decode();
		logic [15:0] ad [5] = '{16'h0000, 16'hFB80, 16'hFF7F, 16'hFF88, 16'hFF80};
		logic [19:0] tb [4] = '{20'h0, 20'h14421, 20'h84421, 20'h84420};
		logic [31:0] q;
		for (int m = 0; m < 4; m++) begin
			ext_reset(m[1:0]);
			wb(mre_pkg::ADR_STAT, 1'b0, 32'h0, q);
			check("stat_ext", q[mre_pkg::STAT_EXT_BIT], 1'b1);
			check("mode_fault", mfault, (m == 0));
			for (int i = 0; i < 5; i++) begin
				@(posedge clk); caddr <= ad[i];
				repeat (2) @(posedge clk);
				#1 check("decode", {d_rom, d_ram, d_regs, d_ext}, tb[m][4*(4-i)+:4]);
			end
		end
	endtask : t_decode
	task automatic t_mode();
		logic [31:0] q;
		for (int m = 3; m > 0; m--) begin
			@(posedge clk); strap <= m[1:0];
			repeat (4) @(posedge clk);
			wb(mre_pkg::ADR_MODE, 1'b1, (m == 2) ? 32'hFF : 32'h0, q);
			wb(mre_pkg::ADR_MODE, 1'b0, 32'h0, q);
			check("mode_reg", q, {24'h0, 6'h39, m[1:0]});
		end
		wb(4'hC, 1'b0, 32'h0, q);
		check("unmapped", q, 32'h0);
	endtask : t_mode
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		boot(16'h1234);
		t_ints();
		t_wdt();
		t_decode();
		t_mode();
		print_verdict();
	end
	initial begin
		#40000;
		err_total++;
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
